// [dv/sap_chk.sv]
`timescale 1ns/10ps
module sap_chk
#(
  parameter int unsigned PKT = 4
)
(
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst_b,
  // Link pins
  input wire logic [1:0] interface_select_pins,
  input wire logic       packet_tick_interrupt,
  input wire logic       sample_frame_sync,
  input wire logic       downstream_data_line,
  input wire logic       csp_bit_clock,
  input wire logic       receive_frame_sync,
  input wire logic       transmit_frame_sync
);
  localparam int unsigned LEAD = (PKT < 16) ? PKT : 16;
  logic [7:0] rx_n_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////////////////////
  // Receive syncs since the last tick; a restart clears it
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
      rx_n_r <= 8'h00;
    else if (packet_tick_interrupt)
      rx_n_r <= 8'h00;
    else if ($rose(receive_frame_sync))
      rx_n_r <= rx_n_r + 8'h01;

  ////////////////////////////////////////////////////////////////////////////////
  sel_dflt_a: assert property (interface_select_pins == 2'h2)
    else $error("select pins off default");
  bclk_high_a: assert property ($rose(csp_bit_clock) |-> ##101 $fell(csp_bit_clock))
    else $error("bit clock high time wrong");
  bclk_low_a: assert property ($fell(csp_bit_clock) |-> ##101 $rose(csp_bit_clock))
    else $error("bit clock stopped or low time wrong");
  rfs_len_a: assert property (
    $rose(receive_frame_sync) |-> ##202 $fell(receive_frame_sync))
    else $error("receive sync not one bit long");
  sync_edge_a: assert property (
    ($rose(receive_frame_sync) || $rose(transmit_frame_sync)) |-> !csp_bit_clock)
    else $error("sync not launched at bit clock fall");
  dd_idle_a: assert property (sample_frame_sync |-> !downstream_data_line)
    else $error("downstream line busy outside window");
  tx_lead_a: assert property ($rose(transmit_frame_sync) |-> rx_n_r >= LEAD)
    else $error("transmit burst ahead of receive lead");
  burst_cap_a: assert property (rx_n_r <= PKT)
    else $error("too many receive syncs in one tick");
endmodule // sap_chk

// [dv/tb_standalone_audio_packet_sequencer.sv]
`timescale 1ns/10ps
module tb_standalone_audio_packet_sequencer;
  logic        core_clk, rst_b, cfg_we, vp_tx_valid, vp_tx_ready, vp_rx_valid;
  logic        mode_on, burst_active, skew_adjust, skew_overrun;
  logic        afe_down_valid, link_ready, pr, pt, got;
  logic [1:0]  sel;
  logic [15:0] vp_rx_data, afe_down_data, rxw, txw, upw;
  int          n_fail, n_compared, nr, nt, nv, i, na, no, nk;

  sap_if bus();
  sap_dev i_sap_dev (.lnk(bus), .core_clk, .rst_b, .cfg_we, .cfg_half_cyc(8'h65),
    .cfg_pkt_words(8'h04), .cfg_chan_ofs(9'h008), .mode_on, .burst_active,
    .skew_adjust, .skew_overrun);
  // Short frames keep the run brief; the device follows the frame sync
  sap_far #(.FRAME_CLKS(64), .STARTUP(4)) i_sap_far (.lnk(bus), .core_clk, .rst_b,
    .sel_strap(sel), .vp_tx_valid, .vp_tx_ready, .vp_tx_data(txw), .vp_rx_valid,
    .vp_rx_data, .afe_up_data(upw), .afe_down_valid, .afe_down_data, .link_ready);
  sap_chk #(.PKT(4)) i_sap_chk (.core_clk, .rst_b,
    .interface_select_pins(bus.interface_select_pins),
    .packet_tick_interrupt(bus.packet_tick_interrupt),
    .sample_frame_sync(bus.sample_frame_sync),
    .downstream_data_line(bus.downstream_data_line), .csp_bit_clock(bus.csp_bit_clock),
    .receive_frame_sync(bus.receive_frame_sync),
    .transmit_frame_sync(bus.transmit_frame_sync));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input bit ok, input string m);
    n_compared++;
    if (!ok)
    begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  // A hang is a mismatch and ends the run at once
  task automatic to(input bit ok);
    if (!ok)
    begin
      n_fail++;
      $display("[FAIL] %0t timeout", $time);
      final_report;
    end
  endtask

  task automatic final_report;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Edges and pulses counted off the wire
  task automatic watch(input int n);
    for (int k = 0; k < n; k++)
    begin
      @(negedge core_clk);
      if (bus.receive_frame_sync === 1'b1 && !pr) nr++;
      if (bus.transmit_frame_sync === 1'b1 && !pt) nt++;
      pr = bus.receive_frame_sync;
      pt = bus.transmit_frame_sync;
      if (vp_rx_valid === 1'b1) nv++;
      if (vp_rx_valid === 1'b1) rxw = vp_rx_data;
      if (afe_down_valid === 1'b1 && afe_down_data === txw) got = 1'b1;
      if (skew_adjust === 1'b1) na++;
      if (skew_overrun === 1'b1) no++;
      if (vp_tx_ready === 1'b1) nk++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_start;
    for (i = 0; i < 50 && mode_on !== 1'b1; i++) @(negedge core_clk);
    chk(mode_on === 1'b1, "mode not entered");
    $display("test start done");
  endtask

  // Link must run a while before any tick; no burst may start early
  task automatic t_link;
    vp_tx_valid = 1'b1;
    for (i = 0; i < 20000 && link_ready !== 1'b1; i++) @(negedge core_clk);
    to(link_ready === 1'b1);
    chk(burst_active === 1'b0, "burst before tick");
    $display("test link done");
  endtask

  task automatic t_burst;
    for (i = 0; i < 100000 && bus.packet_tick_interrupt !== 1'b1; i++) @(negedge core_clk);
    to(bus.packet_tick_interrupt === 1'b1);
    watch(40000);
    chk(nr == 4, "receive sync count");
    chk(nt == 4, "transmit sync count");
    chk(nv == 4, "packet word count");
    chk(rxw === upw, "upstream word");
    chk(nk == 4, "transmit ready count");
    chk(na == 2 && no > 0, "skew budget");
    $display("test burst done");
  endtask

  task automatic t_idle;
    nr = 0;
    nt = 0;
    watch(30000);
    chk(nr + nt == 0, "sync between bursts");
    chk(got === 1'b1, "downstream sample");
    $display("test idle done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  initial
  begin
    {rst_b, cfg_we, vp_tx_valid, pr, pt, got} = 6'h00;
    {n_fail, n_compared, nr, nt, nv, na, no, nk} = '0;
    rxw = 16'h0000;
    sel = 2'h2;
    txw = 16'h9A3C;
    upw = 16'hA5C3;
    repeat (12) @(negedge core_clk);
    rst_b = 1'b1;
    @(negedge core_clk);
    // Short packets keep the run inside one tick period
    cfg_we = 1'b1;
    @(negedge core_clk);
    cfg_we = 1'b0;
    t_start;
    t_link;
    t_burst;
    t_idle;
    final_report;
  end
endmodule // tb_standalone_audio_packet_sequencer

// [rtl/sap_dev.sv]
`timescale 1ns/10ps
module sap_dev
#(
  parameter int unsigned FIFO_DEPTH = sap_pkg::FIFO_DEPTH
)
(
  // Link pins
  sap_if.dev              lnk,
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // Configuration override
  input  wire logic       cfg_we,
  input  wire logic [7:0] cfg_half_cyc,
  input  wire logic [7:0] cfg_pkt_words,
  input  wire logic [8:0] cfg_chan_ofs,
  // Status
  output logic            mode_on,
  output logic            burst_active,
  output logic            skew_adjust,
  output logic            skew_overrun
);
  localparam int unsigned LW = $clog2(FIFO_DEPTH) + 1;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a change counts once stages two and three agree
  logic [6:0] pin_raw;
  logic [6:0] pin_s1_r;
  logic [6:0] pin_s2_r;
  logic [6:0] pin_s3_r;
  logic [6:0] pin_r;
  logic [6:0] pin_d_r;

  assign pin_raw = {lnk.interface_select_pins, lnk.packet_tick_interrupt, lnk.link_bit_clock,
                    lnk.sample_frame_sync, lnk.upstream_data_line, lnk.csp_rx_data};

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_s1_r <= 7'h00;
      pin_s2_r <= 7'h00;
      pin_s3_r <= 7'h00;
      pin_r    <= 7'h00;
      pin_d_r  <= 7'h00;
    end
    else
    begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_r    <= (pin_s2_r & pin_s3_r) | (pin_r & (pin_s2_r | pin_s3_r));
      pin_d_r  <= pin_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mode and configuration
  logic [7:0] half_r;
  logic [7:0] pkt_r;
  logic [8:0] ofs_r;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mode_on <= 1'b0;
      // [RL2] Standalone defaults
      half_r  <= 8'(sap_pkg::CSP_HALF_CYC);
      pkt_r   <= 8'(sap_pkg::PKT_WORDS);
      ofs_r   <= 9'(sap_pkg::CHAN_BIT_OFS);
    end
    else
    begin
      // [RL1] Default mode select
      mode_on <= pin_r[6:5] == sap_pkg::SEL_DEFAULT;
      // [RL9] Host overwrite
      if (cfg_we)
      begin
        half_r <= cfg_half_cyc;
        pkt_r  <= cfg_pkt_words;
        ofs_r  <= cfg_chan_ofs;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compressed port bit clock
  logic       bclk_r;
  logic [7:0] div_r;
  logic [3:0] bit_r;
  logic       tgl;
  logic       fall_en;
  logic       rise_en;

  assign tgl     = mode_on && (div_r >= half_r - 8'h01);
  assign fall_en = tgl & bclk_r;
  assign rise_en = tgl & ~bclk_r;

  // [RL3] Free-running clock
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      div_r  <= 8'h00;
      bclk_r <= 1'b0;
      bit_r  <= 4'h0;
    end
    else if (!mode_on)
    begin
      div_r  <= 8'h00;
      bclk_r <= 1'b0;
    end
    else
    begin
      div_r  <= tgl ? 8'h00 : div_r + 8'h01;
      bclk_r <= bclk_r ^ tgl;
      if (fall_en)
        bit_r <= bit_r + 4'h1;
    end
  end

  assign lnk.csp_bit_clock = bclk_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Burst control
  logic       tick;
  logic       slot_end;
  logic       slot_wrap;
  logic       rx_go;
  logic       tx_go;
  logic [7:0] rx_left_r;
  logic [7:0] tx_left_r;
  logic [4:0] lead_r;
  logic [LW-1:0] rxf_level;
  logic       txf_valid;

  assign tick      = mode_on && pin_r[4] && !pin_d_r[4];
  assign slot_end  = fall_en && bit_r == 4'hE;
  assign slot_wrap = fall_en && bit_r == 4'hF;
  // Two free places: the word in flight lands after this decision
  assign rx_go     = rx_left_r != 8'h00 && rxf_level <= LW'(FIFO_DEPTH - 2);
  // [RL12] Transmit trails receive
  assign tx_go     = tx_left_r != 8'h00 && txf_valid &&
                     (lead_r >= 5'(sap_pkg::TX_LEAD_SYNCS) || rx_left_r == 8'h00);
  assign burst_active = rx_left_r != 8'h00 || tx_left_r != 8'h00;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_left_r <= 8'h00;
      tx_left_r <= 8'h00;
      lead_r    <= 5'h00;
    end
    // [RL11] Tick starts bursts
    else if (tick)
    begin
      rx_left_r <= pkt_r;
      tx_left_r <= pkt_r;
      lead_r    <= 5'h00;
    end
    // [RL5] Exact sync count
    else if (slot_end)
    begin
      if (rx_go)
      begin
        rx_left_r <= rx_left_r - 8'h01;
        if (lead_r < 5'(sap_pkg::TX_LEAD_SYNCS))
          lead_r <= lead_r + 5'h01;
      end
      if (tx_go)
        tx_left_r <= tx_left_r - 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compressed port slots
  logic        rx_sync_r;
  logic        tx_sync_r;
  logic        rx_act_r;
  logic        tx_act_r;
  logic        rx_push_r;
  logic        dout_r;
  logic [15:0] rx_sh_r;
  logic [15:0] tx_sh_r;
  logic [15:0] tx_word_r;
  logic [15:0] txf_data;

  // [RL13] Syncs only while words remain
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_sync_r <= 1'b0;
      tx_sync_r <= 1'b0;
      rx_act_r  <= 1'b0;
      tx_act_r  <= 1'b0;
      tx_word_r <= 16'h0000;
    end
    else if (slot_end)
    begin
      rx_sync_r <= rx_go;
      tx_sync_r <= tx_go;
      if (tx_go)
        tx_word_r <= txf_data;
    end
    else if (slot_wrap)
    begin
      rx_sync_r <= 1'b0;
      tx_sync_r <= 1'b0;
      rx_act_r  <= rx_sync_r;
      tx_act_r  <= tx_sync_r;
    end
  end

  // [RL4] Most significant bit first
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_sh_r   <= 16'h0000;
      rx_push_r <= 1'b0;
      tx_sh_r   <= 16'h0000;
      dout_r    <= 1'b0;
    end
    else
    begin
      rx_push_r <= rise_en && rx_act_r && bit_r == 4'hF;
      if (rise_en && rx_act_r)
        rx_sh_r <= {rx_sh_r[14:0], pin_r[0]};
      if (slot_wrap)
      begin
        dout_r  <= tx_sync_r & tx_word_r[15];
        tx_sh_r <= {tx_word_r[14:0], 1'b0};
      end
      else if (fall_en && tx_act_r)
      begin
        dout_r  <= tx_sh_r[15];
        tx_sh_r <= {tx_sh_r[14:0], 1'b0};
      end
    end
  end

  assign lnk.receive_frame_sync  = rx_sync_r;
  assign lnk.transmit_frame_sync = tx_sync_r;
  assign lnk.csp_tx_data         = dout_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Packet buffers between the two ports
  logic        rxf_in_ready;
  logic        rxf_valid;
  logic        rxf_pop;
  logic [15:0] rxf_data;
  logic        txf_in_ready;
  logic        up_push_r;
  logic [15:0] up_sh_r;

  // [RL16] Buffer covers tick jitter
  sap_fifo #(.W(16), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .in_valid  (rx_push_r),
    .in_ready  (rxf_in_ready),
    .in_data   (rx_sh_r),
    .out_valid (rxf_valid),
    .out_ready (rxf_pop),
    .out_data  (rxf_data),
    .level     (rxf_level)
  );

  sap_fifo #(.W(16), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .in_valid  (up_push_r),
    .in_ready  (txf_in_ready),
    .in_data   (up_sh_r),
    .out_valid (txf_valid),
    .out_ready (slot_end && tx_go),
    .out_data  (txf_data),
    .level     ()
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Sample link, terminal side
  logic        lrise;
  logic [9:0]  lcnt_r;
  logic [9:0]  lcnt_cur;
  logic [9:0]  lbit;
  logic        in_chan;
  logic        chan_first;
  logic        dn_r;
  logic [15:0] dn_sh_r;
  logic [15:0] last_r;
  logic [15:0] dn_word;

  // [RL6] Two link clocks per bit
  assign lrise      = pin_r[3] && !pin_d_r[3];
  assign lcnt_cur   = pin_r[2] ? 10'h000 : lcnt_r + 10'h001;
  assign lbit       = {1'b0, lcnt_cur[9:1]};
  // [RL7] Both intercom channels form one sample
  assign in_chan    = lbit >= {1'b0, ofs_r} && lbit < {1'b0, ofs_r} + 10'(sap_pkg::SLOT_BITS);
  assign chan_first = lbit == {1'b0, ofs_r};
  // [RL19] One pop per frame, never waits on the packet port
  assign rxf_pop    = mode_on && lrise && !lcnt_cur[0] && chan_first;
  assign dn_word    = rxf_valid ? rxf_data : last_r;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lcnt_r    <= 10'h000;
      dn_r      <= 1'b0;
      dn_sh_r   <= 16'h0000;
      last_r    <= 16'h0000;
      up_sh_r   <= 16'h0000;
      up_push_r <= 1'b0;
    end
    else
    begin
      up_push_r <= 1'b0;
      if (lrise)
      begin
        lcnt_r <= lcnt_cur;
        // [RL8] Drive downstream, sample upstream
        if (!in_chan || !mode_on)
          dn_r <= 1'b0;
        else if (!lcnt_cur[0] && chan_first)
        begin
          dn_r    <= dn_word[15];
          dn_sh_r <= {dn_word[14:0], 1'b0};
          last_r  <= dn_word;
        end
        else if (!lcnt_cur[0])
        begin
          dn_r    <= dn_sh_r[15];
          dn_sh_r <= {dn_sh_r[14:0], 1'b0};
        end
        else
        begin
          up_sh_r   <= {up_sh_r[14:0], pin_r[1]};
          up_push_r <= mode_on && lbit == {1'b0, ofs_r} + 10'h00F;
        end
      end
    end
  end

  assign lnk.downstream_data_line = dn_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Long-term skew: repeat on empty, drop on full, budget per tick
  logic       skew_ev;
  logic [1:0] budget_r;

  assign skew_ev = (rxf_pop && !rxf_valid) || (up_push_r && !txf_in_ready);

  // [RL15] Two corrections per tick
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      budget_r     <= 2'(sap_pkg::SKEW_SAMPLES);
      skew_adjust  <= 1'b0;
      skew_overrun <= 1'b0;
    end
    else
    begin
      skew_adjust  <= skew_ev && budget_r != 2'h0;
      skew_overrun <= skew_ev && budget_r == 2'h0;
      if (tick)
        budget_r <= 2'(sap_pkg::SKEW_SAMPLES);
      else if (skew_ev && budget_r != 2'h0)
        budget_r <= budget_r - 2'h1;
    end
  end
endmodule // sap_dev

// [rtl/sap_far.sv]
`timescale 1ns/10ps
module sap_far
#(
  parameter int unsigned FRAME_CLKS = sap_pkg::FRAME_LINK_CLKS,
  parameter int unsigned STARTUP    = sap_pkg::STARTUP_FRAMES
)
(
  // Link pins
  sap_if.far               lnk,
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // Board strap
  input  wire logic [1:0]  sel_strap,
  // Packets to the device
  input  wire logic        vp_tx_valid,
  output logic             vp_tx_ready,
  input  wire logic [15:0] vp_tx_data,
  // Packets from the device
  output logic             vp_rx_valid,
  output logic [15:0]      vp_rx_data,
  // Analog front end samples
  input  wire logic [15:0] afe_up_data,
  output logic             afe_down_valid,
  output logic [15:0]      afe_down_data,
  output logic             link_ready
);
  ////////////////////////////////////////////////////////////////////////////////
  // Link clock and frame, made here
  logic [7:0] ldiv_r;
  logic       lclk_r;
  logic       ltgl;
  logic       lrise;
  logic       lfall;
  logic [9:0] lcnt_r;
  logic [9:0] lnxt;
  logic [9:0] lbit;
  logic       fs_r;
  logic [4:0] pin_s1_r;
  logic [4:0] pin_s2_r;
  logic [4:0] pin_s3_r;
  logic [4:0] pin_r;
  logic [4:0] pin_d_r;

  assign ltgl  = ldiv_r == 8'(sap_pkg::LINK_HALF_CYC - 1);
  assign lrise = ltgl & ~lclk_r;
  assign lfall = ltgl & lclk_r;
  assign lnxt  = lcnt_r == 10'(FRAME_CLKS - 1) ? 10'h000 : lcnt_r + 10'h001;
  assign lbit  = {1'b0, lnxt[9:1]};

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ldiv_r <= 8'h00;
      lclk_r <= 1'b0;
      lcnt_r <= 10'(FRAME_CLKS - 1);
      fs_r   <= 1'b0;
    end
    else
    begin
      ldiv_r <= ltgl ? 8'h00 : ldiv_r + 8'h01;
      lclk_r <= lclk_r ^ ltgl;
      if (lrise)
        lcnt_r <= lnxt;
      if (lfall)
        fs_r <= lcnt_r == 10'(FRAME_CLKS - 1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Startup hold-off and 10 ms tick counted in frames
  logic [4:0] up_cnt_r;
  logic [6:0] tick_cnt_r;
  logic       tick_r;
  logic       sel_r;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      up_cnt_r   <= 5'h00;
      tick_cnt_r <= 7'h00;
      tick_r     <= 1'b0;
    end
    else if (lrise)
    begin
      tick_r <= 1'b0;
      if (lnxt == 10'h000)
      begin
        // [RL14] Link runs before first tick
        if (up_cnt_r != 5'(STARTUP))
          up_cnt_r <= up_cnt_r + 5'h01;
        else
        begin
          // [RL17] Period counted in link frames
          // [RL18] Tick locked to frame sync
          tick_cnt_r <= tick_cnt_r == 7'(sap_pkg::TICK_FRAMES - 1) ? 7'h00 : tick_cnt_r + 7'h01;
          // [RL10] One tick per period
          tick_r     <= tick_cnt_r == 7'h00;
        end
      end
    end
  end

  assign link_ready = up_cnt_r == 5'(STARTUP);

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      sel_r <= 1'b0;
    else
      sel_r <= 1'b1;
  end

  assign lnk.interface_select_pins = sel_r ? sel_strap : sap_pkg::SEL_DEFAULT;
  assign lnk.packet_tick_interrupt = tick_r;
  assign lnk.link_bit_clock        = lclk_r;
  assign lnk.sample_frame_sync     = fs_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Front end samples in the intercom channels
  logic        in_chan;
  logic        du_r;
  logic [15:0] up_sh_r;
  logic [15:0] dn_sh_r;

  assign in_chan = lbit >= 10'(sap_pkg::CHAN_BIT_OFS) &&
                   lbit < 10'(sap_pkg::CHAN_BIT_OFS + sap_pkg::SLOT_BITS);

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      du_r           <= 1'b0;
      up_sh_r        <= 16'h0000;
      dn_sh_r        <= 16'h0000;
      afe_down_valid <= 1'b0;
      afe_down_data  <= 16'h0000;
    end
    else
    begin
      afe_down_valid <= 1'b0;
      if (lrise && !in_chan)
        du_r <= 1'b0;
      else if (lrise && !lnxt[0] && lbit == 10'(sap_pkg::CHAN_BIT_OFS))
      begin
        du_r    <= afe_up_data[15];
        up_sh_r <= {afe_up_data[14:0], 1'b0};
      end
      else if (lrise && !lnxt[0])
      begin
        du_r    <= up_sh_r[15];
        up_sh_r <= {up_sh_r[14:0], 1'b0};
      end
      else if (lrise)
      begin
        dn_sh_r <= {dn_sh_r[14:0], pin_r[0]};
        if (lbit == 10'(sap_pkg::CHAN_BIT_OFS + sap_pkg::SLOT_BITS - 1))
        begin
          afe_down_valid <= 1'b1;
          afe_down_data  <= {dn_sh_r[14:0], pin_r[0]};
        end
      end
    end
  end

  assign lnk.upstream_data_line = du_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Compressed port, slave side; pins cross in through three stages
  logic       brise;
  logic       bfall;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_s1_r <= 5'h00;
      pin_s2_r <= 5'h00;
      pin_s3_r <= 5'h00;
      pin_r    <= 5'h00;
      pin_d_r  <= 5'h00;
    end
    else
    begin
      pin_s1_r <= {lnk.csp_bit_clock, lnk.receive_frame_sync, lnk.transmit_frame_sync,
                   lnk.csp_tx_data, lnk.downstream_data_line};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_r    <= (pin_s2_r & pin_s3_r) | (pin_r & (pin_s2_r | pin_s3_r));
      pin_d_r  <= pin_r;
    end
  end

  assign brise       = pin_r[4] && !pin_d_r[4];
  assign bfall       = !pin_r[4] && pin_d_r[4];

  logic        r_arm_r;
  logic [3:0]  r_cnt_r;
  logic [15:0] r_sh_r;
  logic        sdo_r;
  logic        t_arm_r;
  logic        t_act_r;
  logic [3:0]  t_bit_r;
  logic [15:0] t_sh_r;
  logic [15:0] w;

  assign vp_tx_ready = bfall && r_arm_r;
  assign w           = vp_tx_valid ? vp_tx_data : 16'h0000;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      r_arm_r <= 1'b0;
      r_cnt_r <= 4'h0;
      r_sh_r  <= 16'h0000;
      sdo_r   <= 1'b0;
    end
    else if (brise && pin_r[3])
      r_arm_r <= 1'b1;
    else if (bfall && r_arm_r)
    begin
      r_arm_r <= 1'b0;
      sdo_r   <= w[15];
      r_sh_r  <= {w[14:0], 1'b0};
      r_cnt_r <= 4'hF;
    end
    else if (bfall)
    begin
      sdo_r   <= (r_cnt_r != 4'h0) & r_sh_r[15];
      r_sh_r  <= {r_sh_r[14:0], 1'b0};
      r_cnt_r <= r_cnt_r - {3'h0, r_cnt_r != 4'h0};
    end
  end

  assign lnk.csp_rx_data = sdo_r;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      t_arm_r     <= 1'b0;
      t_act_r     <= 1'b0;
      t_bit_r     <= 4'h0;
      t_sh_r      <= 16'h0000;
      vp_rx_valid <= 1'b0;
      vp_rx_data  <= 16'h0000;
    end
    else
    begin
      vp_rx_valid <= 1'b0;
      if (bfall && t_arm_r)
      begin
        t_arm_r <= 1'b0;
        t_act_r <= 1'b1;
        t_bit_r <= 4'h0;
      end
      if (brise)
      begin
        if (pin_r[2])
          t_arm_r <= 1'b1;
        if (t_act_r)
        begin
          t_sh_r  <= {t_sh_r[14:0], pin_r[1]};
          t_bit_r <= t_bit_r + 4'h1;
          if (t_bit_r == 4'hF)
          begin
            t_act_r     <= 1'b0;
            vp_rx_valid <= 1'b1;
            vp_rx_data  <= {t_sh_r[14:0], pin_r[1]};
          end
        end
      end
    end
  end
endmodule // sap_far

// [rtl/sap_fifo.sv]
`timescale 1ns/10ps
module sap_fifo
#(
  parameter int unsigned W     = 16,
  parameter int unsigned DEPTH = 16,
  parameter int unsigned AW    = $clog2(DEPTH)
)
(
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          rst_b,
  // Fill side
  input  wire logic          in_valid,
  output logic               in_ready,
  input  wire logic [W-1:0]  in_data,
  // Drain side
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic [W-1:0]       out_data,
  output logic [AW:0]        level
);
  // Depth must be a power of two; pointers carry one wrap bit
  logic [W-1:0] mem_r [DEPTH];
  logic [AW:0]  wr_r;
  logic [AW:0]  rd_r;

  assign level     = wr_r - rd_r;
  assign in_ready  = level != (AW+1)'(DEPTH);
  assign out_valid = level != '0;
  assign out_data  = mem_r[rd_r[AW-1:0]];

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_r <= '0;
      rd_r <= '0;
    end
    else
    begin
      if (in_valid && in_ready)
        wr_r <= wr_r + (AW+1)'(1);
      if (out_valid && out_ready)
        rd_r <= rd_r + (AW+1)'(1);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (in_valid && in_ready)
      mem_r[wr_r[AW-1:0]] <= in_data;
  end
endmodule // sap_fifo

// [rtl/sap_if.sv]
`timescale 1ns/10ps
interface sap_if;
  logic [1:0] interface_select_pins;
  logic       packet_tick_interrupt;
  logic       link_bit_clock;
  logic       sample_frame_sync;
  logic       downstream_data_line;
  logic       upstream_data_line;
  logic       csp_bit_clock;
  logic       receive_frame_sync;
  logic       transmit_frame_sync;
  logic       csp_rx_data;
  logic       csp_tx_data;

  modport dev (
    input  interface_select_pins, packet_tick_interrupt, link_bit_clock, sample_frame_sync,
    input  upstream_data_line, csp_rx_data,
    output downstream_data_line, csp_bit_clock, receive_frame_sync, transmit_frame_sync,
    output csp_tx_data
  );
  modport far (
    output interface_select_pins, packet_tick_interrupt, link_bit_clock, sample_frame_sync,
    output upstream_data_line, csp_rx_data,
    input  downstream_data_line, csp_bit_clock, receive_frame_sync, transmit_frame_sync,
    input  csp_tx_data
  );
endinterface // sap_if

// [rtl/sap_pkg.sv]
// Notes on behaviour
// [RL1] Select pins reading 10 enable this mode
// [RL2] Reset values configure both ports standalone
// [RL3] Compressed port bit clock runs continuously
// [RL4] Sixteen-bit slots, most significant bit first
// [RL5] Frame syncs only in exact-length bursts
// [RL6] Link bit clock is twice bit rate
// [RL7] Linear samples use the two intercom channels
// [RL8] Downstream line driven, upstream line sampled
// [RL9] Host may overwrite configuration any time
// [RL10] Far end raises packet tick every 10 ms
// [RL11] Each tick starts a sync burst
// [RL12] Bursts independent, receive leads by sixteen
// [RL13] Idle between bursts until next tick
// [RL14] Link clocks stable before first tick
// [RL15] Insert or drop two samples per tick
// [RL16] Buffer absorbs fifteen percent period jitter
// [RL17] Tick period measured in link frames
// [RL18] Far end locks tick to frame sync
// [RL19] Packet traffic never stalls sample flow
package sap_pkg;
  localparam int unsigned CLK_HZ          = 250_000_000;
  localparam int unsigned CLK_NS          = 4;
  localparam logic [1:0]  SEL_DEFAULT     = 2'h2;
  localparam int unsigned CSP_BCLK_HZ     = 1_230_000;
  localparam int unsigned CSP_HALF_CYC    = CLK_HZ / (2 * CSP_BCLK_HZ);
  localparam int unsigned SLOT_BITS       = 16;
  localparam int unsigned TX_LEAD_SYNCS   = 16;
  localparam int unsigned SAMPLE_HZ       = 8000;
  localparam int unsigned TICK_MS         = 10;
  localparam int unsigned TICK_FRAMES     = SAMPLE_HZ * TICK_MS / 1000;
  localparam int unsigned PKT_WORDS       = TICK_FRAMES;
  localparam int unsigned SKEW_SAMPLES    = 2;
  localparam int unsigned JITTER_PCT      = 15;
  localparam int unsigned FIFO_DEPTH      = 16;
  localparam int unsigned LINK_CLK_NS     = 160;
  localparam int unsigned LINK_HALF_CYC   = LINK_CLK_NS / (2 * CLK_NS);
  localparam int unsigned FRAME_LINK_CLKS = 1_000_000_000 / (SAMPLE_HZ * LINK_CLK_NS);
  localparam int unsigned CHAN_BIT_OFS    = 8;
  localparam int unsigned STARTUP_FRAMES  = 16;
endpackage
